// ### inc/pga_ctrl_pkg.sv
package pga_ctrl_pkg;

   // Register addresses on the control port
   localparam logic [6:0] REG_PWR   = 7'h02;
   localparam logic [6:0] REG_ALC   = 7'h20;
   localparam logic [6:0] REG_ROUTE = 7'h2C;
   localparam logic [6:0] REG_LGAIN = 7'h2D;
   localparam logic [6:0] REG_RGAIN = 7'h2E;

   // Fixed 2-wire device address
   localparam logic [6:0] DEV_ADDR = 7'h1A;

   // Field positions
   localparam int PWR_L_BIT    = 2;
   localparam int PWR_R_BIT    = 3;
   localparam int RT_L_NONINV  = 0;
   localparam int RT_L_INV     = 1;
   localparam int RT_L_SECOND  = 2;
   localparam int RT_R_NONINV  = 4;
   localparam int RT_R_INV     = 5;
   localparam int RT_R_SECOND  = 6;
   localparam int GAIN_W       = 6;
   localparam int MUTE_BIT     = 6;
   localparam int ZC_BIT       = 7;
   localparam int VU_BIT       = 8;
   localparam int ALC_R_BIT    = 7;
   localparam int ALC_L_BIT    = 8;

   // Values after reset
   localparam logic [8:0] PWR_RST   = 9'h000;
   localparam logic [8:0] ALC_RST   = 9'h000;
   localparam logic [8:0] ROUTE_RST = 9'h033;
   localparam logic [7:0] GAIN_RST  = 8'h10;

   // Counts
   localparam int WORD_BITS   = 16;
   localparam int TIMEOUT_DEF = 1048576;

   // Serial control word: address then data
   typedef struct packed {
      logic [6:0] addr;
      logic [8:0] data;
   } ctl_word_t;

   // Per-channel controls toward the analogue stage
   typedef struct packed {
      logic              power;
      logic              noninv;
      logic              inv;
      logic              second;
      logic              mute;
      logic              alc;
      logic [GAIN_W-1:0] gain;
   } chan_ctl_t;

endpackage

// ### rtl/ctrl_port_rx.sv
`timescale 1ns/10ps
`default_nettype none
module ctrl_port_rx
   import pga_ctrl_pkg::*;
(
   input  wire logic sclk,
   input  wire logic rst,
   input  wire logic csb,
   input  wire logic sdin,
   output ctl_word_t word_ff,
   output logic      word_tgl_ff
);

   logic [WORD_BITS-2:0] shift_ff;
   logic [WORD_BITS-2:0] nxt_shift;
   logic [3:0]           cnt_ff;
   logic [3:0]           nxt_cnt;
   ctl_word_t            nxt_word;
   logic                 nxt_tgl;

   // Shift in bits, publish every sixteenth with a toggle
   always_comb
   begin
      nxt_shift = {shift_ff[WORD_BITS-3:0], sdin};
      nxt_cnt   = cnt_ff + 4'h1;
      nxt_word  = word_ff;
      nxt_tgl   = word_tgl_ff;
      if (cnt_ff == 4'hF)
      begin
         nxt_word = {shift_ff, sdin};
         nxt_tgl  = ~word_tgl_ff;
      end
   end

   // Frame position cleared while the select is high
   always_ff @(posedge sclk or posedge csb or posedge rst)
   begin
      if (csb || rst)
      begin
         shift_ff <= '0;
         cnt_ff   <= 4'h0;
      end
      else
      begin
         shift_ff <= nxt_shift;
         cnt_ff   <= nxt_cnt;
      end
   end

   // Held word, stable until the next full word
   always_ff @(posedge sclk or posedge rst)
   begin
      if (rst)
      begin
         word_ff     <= '0;
         word_tgl_ff <= 1'b0;
      end
      else
      begin
         word_ff     <= nxt_word;
         word_tgl_ff <= nxt_tgl;
      end
   end

endmodule
`default_nettype wire

// ### rtl/gain_apply.sv
`timescale 1ns/10ps
`default_nettype none
module gain_apply
   import pga_ctrl_pkg::*;
#(
   parameter int SAMPLE_W = 16
)
(
   input  wire logic                       mclk,
   input  wire logic                       rst,
   input  wire logic                       upd_req,
   input  wire logic                       zc_en,
   input  wire logic [GAIN_W-1:0]          pending,
   input  wire logic signed [SAMPLE_W-1:0] sample,
   input  wire logic                       sample_valid,
   input  wire logic                       timeout_tick,
   output logic [GAIN_W-1:0]               active_ff
);

   logic [GAIN_W-1:0] snap_ff, nxt_snap, nxt_active;
   logic              wait_ff, nxt_wait;
   logic              seen_ff, nxt_seen;
   logic              sign_ff, nxt_sign;
   logic              zc;

   // Apply now, on a zero crossing, or after the timeout
   always_comb
   begin
      zc         = sample_valid && (sample[SAMPLE_W-1] != sign_ff);
      nxt_sign   = sample_valid ? sample[SAMPLE_W-1] : sign_ff;
      nxt_snap   = snap_ff;
      nxt_active = active_ff;
      nxt_wait   = wait_ff;
      nxt_seen   = seen_ff;
      if (upd_req)
      begin
         nxt_snap = pending;
         if (!zc_en)
         begin
            nxt_active = pending;
            nxt_wait   = 1'b0;
         end
         else
         begin
            nxt_wait = 1'b1;
            nxt_seen = 1'b0;
         end
      end
      else if (wait_ff)
      begin
         if (zc || (timeout_tick && seen_ff))
         begin
            nxt_active = snap_ff;
            nxt_wait   = 1'b0;
         end
         else if (timeout_tick)
            nxt_seen = 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         snap_ff   <= GAIN_RST[GAIN_W-1:0];
         active_ff <= GAIN_RST[GAIN_W-1:0];
         wait_ff   <= 1'b0;
         seen_ff   <= 1'b0;
         sign_ff   <= 1'b0;
      end
      else
      begin
         snap_ff   <= nxt_snap;
         active_ff <= nxt_active;
         wait_ff   <= nxt_wait;
         seen_ff   <= nxt_seen;
         sign_ff   <= nxt_sign;
      end
   end

   property p_direct;
      @(posedge mclk) disable iff (rst)
      (upd_req && !zc_en) |=> (active_ff == $past(pending));
   endproperty
   a_direct: assert property (p_direct)
      else $error("direct gain update not applied");

   property p_hold;
      @(posedge mclk) disable iff (rst)
      (!upd_req && !wait_ff) |=> $stable(active_ff);
   endproperty
   a_hold: assert property (p_hold)
      else $error("gain changed without update strobe");

   property p_timeout;
      @(posedge mclk) disable iff (rst)
      (wait_ff && !upd_req && timeout_tick && seen_ff)
      |=> (!wait_ff && active_ff == $past(snap_ff));
   endproperty
   a_timeout: assert property (p_timeout)
      else $error("timeout did not force gain update");

   property p_zero_cross;
      @(posedge mclk) disable iff (rst)
      (wait_ff && !upd_req && zc) |=> (active_ff == $past(snap_ff));
   endproperty
   a_zero_cross: assert property (p_zero_cross)
      else $error("zero crossing did not apply gain");

endmodule
`default_nettype wire

// ### rtl/input_pga_control_regs.sv
`timescale 1ns/10ps
`default_nettype none
//
// Function
// - Power bit 2 enables left gain stage, bit 3 right; both reset off.
// - Left noninverting switch on bit 0 (reset 1), second pin bit 2 (0).
// - Left inverting pin connects while routing bit 1 set; reset one.
// - Right switches on bits 4, 5, 6; resets one, one, zero.
// - Six-bit gain code, -12dB at zero, 0.75dB steps, resets to 0dB.
// - One gain code drives every input path of its channel.
// - Bit 6 mutes the gain stage and isolates it from boost.
// - Zero-cross flag off applies at once; on waits for a crossing.
// - New gains wait pending until bit 8 written in either gain register.
// - Select bits 8:7 hand right, left or both gains to level control.
// - Strap picks 2- or 3-wire port; 2-wire answers only 0011010.
// - Strap high selects 3-wire mode, low selects 2-wire mode.
// - Without a crossing, a timeout forces the update in one to two periods.
// - Writes ignored during reset; registers leave reset at defaults.
module input_pga_control_regs
   import pga_ctrl_pkg::*;
#(
   parameter int SAMPLE_W       = 16,
   parameter int TIMEOUT_CYCLES = TIMEOUT_DEF
)
(
   input  wire logic                       mclk,
   input  wire logic                       rst,
   input  wire logic                       sclk,
   input  wire logic                       csb,
   input  wire logic                       sdin,
   input  wire logic                       mode_sel,
   input  wire logic signed [SAMPLE_W-1:0] left_sample,
   input  wire logic signed [SAMPLE_W-1:0] right_sample,
   input  wire logic                       sample_valid,
   input  wire logic [GAIN_W-1:0]          left_alc_gain,
   input  wire logic [GAIN_W-1:0]          right_alc_gain,
   output chan_ctl_t                       left_ctl,
   output chan_ctl_t                       right_ctl,
   output logic                            sda_out,
   output logic                            sda_oe
);

   localparam int TW = $clog2(TIMEOUT_CYCLES);

   typedef enum logic [1:0] {
      TW_IDLE = 2'b00,
      TW_BITS = 2'b01,
      TW_ACK  = 2'b11,
      TW_SKIP = 2'b10
   } tw_state_t;

   ////////////////////////////////////////////////////////////////////////
   // Serial receiver on the link clock

   ctl_word_t rx_word;
   logic      rx_tgl;

   ctrl_port_rx u_rx (
      .sclk        (sclk),
      .rst         (rst),
      .csb         (csb),
      .sdin        (sdin),
      .word_ff     (rx_word),
      .word_tgl_ff (rx_tgl)
   );

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers: mode, scl, sda, word toggle

   logic [3:0] s1_ff, s2_ff, s3_ff;
   logic       mode_3w, scl_s, scl_d, sda_s, sda_d;
   logic       scl_rise, scl_fall, tw_start, tw_stop, tw3_commit;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s1_ff <= 4'h0;
         s2_ff <= 4'h0;
         s3_ff <= 4'h0;
      end
      else
      begin
         s1_ff <= {mode_sel, sclk, sdin, rx_tgl};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // Edges and bus conditions from the second and third stages
   always_comb
   begin
      mode_3w    = s2_ff[3];
      scl_s      = s2_ff[2];
      scl_d      = s3_ff[2];
      sda_s      = s2_ff[1];
      sda_d      = s3_ff[1];
      scl_rise   = scl_s && !scl_d;
      scl_fall   = !scl_s && scl_d;
      tw_start   = scl_s && scl_d && sda_d && !sda_s;
      tw_stop    = scl_s && scl_d && !sda_d && sda_s;
      tw3_commit = mode_3w && (s2_ff[0] != s3_ff[0]);
   end

   ////////////////////////////////////////////////////////////////////////
   // Two-wire write decoder: device address, two data bytes

   tw_state_t tw_state_ff, nxt_tw_state;
   logic [3:0] tw_cnt_ff, nxt_tw_cnt;
   logic [1:0] tw_idx_ff, nxt_tw_idx;
   logic [7:0] tw_sh_ff, nxt_tw_sh, tw_hi_ff, nxt_tw_hi;
   logic       nxt_oe, tw_commit;

   always_comb
   begin
      nxt_tw_state = tw_state_ff;
      nxt_tw_cnt   = tw_cnt_ff;
      nxt_tw_idx   = tw_idx_ff;
      nxt_tw_sh    = tw_sh_ff;
      nxt_tw_hi    = tw_hi_ff;
      nxt_oe       = sda_oe;
      tw_commit    = 1'b0;
      if (mode_3w)
      begin
         nxt_tw_state = TW_IDLE;
         nxt_oe       = 1'b0;
      end
      else if (tw_start)
      begin
         nxt_tw_state = TW_BITS;
         nxt_tw_cnt   = 4'h0;
         nxt_tw_idx   = 2'd0;
         nxt_oe       = 1'b0;
      end
      else if (tw_stop)
      begin
         nxt_tw_state = TW_IDLE;
         nxt_oe       = 1'b0;
      end
      else
      begin
         case (tw_state_ff)
            TW_BITS:
            begin
               if (scl_rise)
               begin
                  nxt_tw_sh  = {tw_sh_ff[6:0], sda_s};
                  nxt_tw_cnt = tw_cnt_ff + 4'h1;
               end
               else if (scl_fall && tw_cnt_ff == 4'h8)
               begin
                  nxt_tw_cnt = 4'h0;
                  if (tw_idx_ff == 2'd0 &&
                      (tw_sh_ff[7:1] != DEV_ADDR || tw_sh_ff[0]))
                     nxt_tw_state = TW_SKIP;
                  else
                  begin
                     nxt_tw_state = TW_ACK;
                     nxt_oe       = 1'b1;
                     if (tw_idx_ff == 2'd1)
                        nxt_tw_hi = tw_sh_ff;
                  end
               end
            end
            TW_ACK:
            begin
               if (scl_fall)
               begin
                  nxt_oe = 1'b0;
                  if (tw_idx_ff == 2'd2)
                  begin
                     tw_commit    = 1'b1;
                     nxt_tw_state = TW_SKIP;
                  end
                  else
                  begin
                     nxt_tw_idx   = tw_idx_ff + 2'd1;
                     nxt_tw_state = TW_BITS;
                  end
               end
            end
            default:
            begin
               nxt_tw_state = tw_state_ff;
            end
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         tw_state_ff <= TW_IDLE;
         tw_cnt_ff   <= 4'h0;
         tw_idx_ff   <= 2'd0;
         tw_sh_ff    <= 8'h00;
         tw_hi_ff    <= 8'h00;
         sda_oe      <= 1'b0;
         sda_out     <= 1'b0;
      end
      else
      begin
         tw_state_ff <= nxt_tw_state;
         tw_cnt_ff   <= nxt_tw_cnt;
         tw_idx_ff   <= nxt_tw_idx;
         tw_sh_ff    <= nxt_tw_sh;
         tw_hi_ff    <= nxt_tw_hi;
         sda_oe      <= nxt_oe;
         sda_out     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register bank and update strobe

   logic       wr_en_ff, nxt_wr_en;
   ctl_word_t  wr_word_ff, nxt_wr_word;
   logic [8:0] pwr_ff, nxt_pwr, alc_ff, nxt_alc, route_ff, nxt_route;
   logic [7:0] lgain_ff, nxt_lgain, rgain_ff, nxt_rgain;
   logic       upd_ff, nxt_upd;

   always_comb
   begin
      nxt_wr_en   = tw_commit || tw3_commit;
      nxt_wr_word = tw3_commit ? rx_word : ctl_word_t'({tw_hi_ff, tw_sh_ff});
      nxt_pwr     = pwr_ff;
      nxt_alc     = alc_ff;
      nxt_route   = route_ff;
      nxt_lgain   = lgain_ff;
      nxt_rgain   = rgain_ff;
      nxt_upd     = 1'b0;
      if (wr_en_ff)
      begin
         if (wr_word_ff.addr == REG_PWR)
            nxt_pwr = wr_word_ff.data;
         else if (wr_word_ff.addr == REG_ALC)
            nxt_alc = wr_word_ff.data;
         else if (wr_word_ff.addr == REG_ROUTE)
            nxt_route = wr_word_ff.data;
         else if (wr_word_ff.addr == REG_LGAIN)
         begin
            nxt_lgain = wr_word_ff.data[7:0];
            nxt_upd   = wr_word_ff.data[VU_BIT];
         end
         else if (wr_word_ff.addr == REG_RGAIN)
         begin
            nxt_rgain = wr_word_ff.data[7:0];
            nxt_upd   = wr_word_ff.data[VU_BIT];
         end
      end
   end

   // Reset wins over any write in flight
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         wr_en_ff   <= 1'b0;
         wr_word_ff <= '0;
         pwr_ff     <= PWR_RST;
         alc_ff     <= ALC_RST;
         route_ff   <= ROUTE_RST;
         lgain_ff   <= GAIN_RST;
         rgain_ff   <= GAIN_RST;
         upd_ff     <= 1'b0;
      end
      else
      begin
         wr_en_ff   <= nxt_wr_en;
         wr_word_ff <= nxt_wr_word;
         pwr_ff     <= nxt_pwr;
         alc_ff     <= nxt_alc;
         route_ff   <= nxt_route;
         lgain_ff   <= nxt_lgain;
         rgain_ff   <= nxt_rgain;
         upd_ff     <= nxt_upd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Zero-cross timeout tick and per-channel gain apply

   logic [TW-1:0] tmo_cnt_ff, nxt_tmo_cnt;
   logic          tick_ff, nxt_tick;

   always_comb
   begin
      nxt_tick    = (tmo_cnt_ff == TW'(TIMEOUT_CYCLES - 1));
      nxt_tmo_cnt = nxt_tick ? '0 : tmo_cnt_ff + 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         tmo_cnt_ff <= '0;
         tick_ff    <= 1'b0;
      end
      else
      begin
         tmo_cnt_ff <= nxt_tmo_cnt;
         tick_ff    <= nxt_tick;
      end
   end

   logic [GAIN_W-1:0]          pend [2];
   logic [GAIN_W-1:0]          act [2];
   logic                       zc_en [2];
   logic signed [SAMPLE_W-1:0] smp [2];

   assign pend[0]  = lgain_ff[GAIN_W-1:0];
   assign pend[1]  = rgain_ff[GAIN_W-1:0];
   assign zc_en[0] = lgain_ff[ZC_BIT];
   assign zc_en[1] = rgain_ff[ZC_BIT];
   assign smp[0]   = left_sample;
   assign smp[1]   = right_sample;

   // One apply unit per channel, shared strobe
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++)
      begin : g_ch
         gain_apply #(.SAMPLE_W(SAMPLE_W)) u_apply (
            .mclk         (mclk),
            .rst          (rst),
            .upd_req      (upd_ff),
            .zc_en        (zc_en[ch]),
            .pending      (pend[ch]),
            .sample       (smp[ch]),
            .sample_valid (sample_valid),
            .timeout_tick (tick_ff),
            .active_ff    (act[ch])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Output controls toward the analogue stages

   function automatic chan_ctl_t build_ctl(
      input logic              pwr,
      input logic              noninv,
      input logic              inv,
      input logic              second,
      input logic              mute,
      input logic              alc,
      input logic [GAIN_W-1:0] alc_gain,
      input logic [GAIN_W-1:0] active
   );
      chan_ctl_t c;
      c.power  = pwr;
      c.noninv = noninv;
      c.inv    = inv;
      c.second = second;
      c.mute   = mute;
      c.alc    = alc;
      c.gain   = alc ? alc_gain : active;
      return c;
   endfunction

   chan_ctl_t nxt_left, nxt_right;

   always_comb
   begin
      nxt_left  = build_ctl(pwr_ff[PWR_L_BIT], route_ff[RT_L_NONINV],
                            route_ff[RT_L_INV], route_ff[RT_L_SECOND],
                            lgain_ff[MUTE_BIT], alc_ff[ALC_L_BIT],
                            left_alc_gain, act[0]);
      nxt_right = build_ctl(pwr_ff[PWR_R_BIT], route_ff[RT_R_NONINV],
                            route_ff[RT_R_INV], route_ff[RT_R_SECOND],
                            rgain_ff[MUTE_BIT], alc_ff[ALC_R_BIT],
                            right_alc_gain, act[1]);
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         left_ctl  <= build_ctl(PWR_RST[PWR_L_BIT], ROUTE_RST[RT_L_NONINV],
                                ROUTE_RST[RT_L_INV], ROUTE_RST[RT_L_SECOND],
                                GAIN_RST[MUTE_BIT], 1'b0, '0,
                                GAIN_RST[GAIN_W-1:0]);
         right_ctl <= build_ctl(PWR_RST[PWR_R_BIT], ROUTE_RST[RT_R_NONINV],
                                ROUTE_RST[RT_R_INV], ROUTE_RST[RT_R_SECOND],
                                GAIN_RST[MUTE_BIT], 1'b0, '0,
                                GAIN_RST[GAIN_W-1:0]);
      end
      else
      begin
         left_ctl  <= nxt_left;
         right_ctl <= nxt_right;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   sequence s_wr(logic [6:0] a);
      wr_en_ff && wr_word_ff.addr == a;
   endsequence

   property p_power;
      @(posedge mclk) disable iff (rst)
      s_wr(REG_PWR) |-> ##2 (left_ctl.power == $past(wr_word_ff.data[2], 2));
   endproperty
   a_power: assert property (p_power)
      else $error("left stage power does not follow write");

   property p_route_rst;
      @(posedge mclk)
      rst |=> (left_ctl.noninv && !left_ctl.second);
   endproperty
   a_route_rst: assert property (p_route_rst)
      else $error("left routing reset value wrong");

   property p_inv_rst;
      @(posedge mclk)
      rst |=> (left_ctl.inv && right_ctl.inv && left_ctl.gain == 6'h10);
   endproperty
   a_inv_rst: assert property (p_inv_rst)
      else $error("inverting pin or gain reset value wrong");

   property p_route_wr;
      @(posedge mclk) disable iff (rst)
      s_wr(REG_ROUTE) |-> ##2
         (right_ctl.second == $past(wr_word_ff.data[6], 2));
   endproperty
   a_route_wr: assert property (p_route_wr)
      else $error("right second pin switch wrong");

   property p_mute;
      @(posedge mclk) disable iff (rst)
      s_wr(REG_RGAIN) |-> ##2 (right_ctl.mute == $past(wr_word_ff.data[6], 2));
   endproperty
   a_mute: assert property (p_mute)
      else $error("mute does not follow write");

   property p_alc;
      @(posedge mclk) disable iff (rst)
      (alc_ff[ALC_L_BIT] && $stable(alc_ff)) |=>
         (left_ctl.alc && left_ctl.gain == $past(left_alc_gain));
   endproperty
   a_alc: assert property (p_alc)
      else $error("level control did not take left gain");

   property p_ack;
      @(posedge mclk) disable iff (rst)
      ($rose(sda_oe) && tw_idx_ff == 2'd0) |-> (tw_sh_ff == {DEV_ADDR, 1'b0});
   endproperty
   a_ack: assert property (p_ack)
      else $error("acknowledged a foreign device address");

   property p_mode;
      @(posedge mclk) disable iff (rst)
      mode_3w |=> (tw_state_ff == TW_IDLE && !sda_oe);
   endproperty
   a_mode: assert property (p_mode)
      else $error("2-wire decoder active in 3-wire mode");

   property p_reset_ignore;
      @(posedge mclk)
      rst |=> (!wr_en_ff && route_ff == ROUTE_RST && lgain_ff == GAIN_RST);
   endproperty
   a_reset_ignore: assert property (p_reset_ignore)
      else $error("register left reset without default");

   property p_strobe;
      @(posedge mclk) disable iff (rst)
      (s_wr(REG_LGAIN) ##0 wr_word_ff.data[VU_BIT]) |=>
         (upd_ff && lgain_ff == $past(wr_word_ff.data[7:0]));
   endproperty
   a_strobe: assert property (p_strobe)
      else $error("update strobe not raised on gain write");

endmodule
`default_nettype wire

// ### testbench/host_port_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_port_model
   import pga_ctrl_pkg::*;
(
   input  wire logic sda_oe,
   output logic      sclk,
   output logic      csb,
   output logic      sdin
);
   // Idle port: clock still, chip deselected
   initial
   begin
      sclk = 1'b0;
      csb  = 1'b1;
      sdin = 1'b0;
   end

   // One 3-wire word, MSB first, clock only within frame
   task automatic send(input ctl_word_t w);
      #13; // Off the system clock edge
      csb = 1'b0;
      for (int i = WORD_BITS - 1; i >= 0; i--)
      begin
         sdin = w[i];
         #40 sclk = 1'b1;
         #40 sclk = 1'b0;
      end
      #40 csb = 1'b1;
      sdin = ~sdin; // No stale data after frame
   endtask

   // One 2-wire write: start, device byte, two data bytes, stop
   task automatic send2(input logic [7:0] dev, input ctl_word_t w,
                        output int acks);
      logic [23:0] b;
      b    = {dev, w};
      acks = 0;
      #13;
      sdin = 1'b1;
      sclk = 1'b1;
      #600 sdin = 1'b0; // Start
      #600 sclk = 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         sdin = b[i];
         #600 sclk = 1'b1;
         #600 sclk = 1'b0;
         if (i % 8 == 0)
         begin
            sdin = 1'b1; // Released for the ack slot
            #600 sclk = 1'b1;
            if (sda_oe === 1'b1)
               acks++;
            #600 sclk = 1'b0;
         end
      end
      sdin = 1'b0;
      #600 sclk = 1'b1;
      #600 sdin = 1'b1; // Stop
   endtask
endmodule
`default_nettype wire

// ### testbench/input_pga_control_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module input_pga_control_regs_tb
   import pga_ctrl_pkg::*;
;
   logic               mclk = 1'b0;
   logic               rst = 1'b1;
   logic               sv = 1'b0;
   logic signed [15:0] ls = 16'sh0100;
   logic [5:0]         ag[2] = '{6'h00, 6'h00};
   logic               mode = 1'b1;
   logic               sclk, csb, sdin, oe;
   chan_ctl_t          lc, rc;
   logic [8:0]         pwr, route, sel;
   logic [5:0]         act[2];
   logic [1:0]         mute;
   int                 n_fail, compares, acks;

   input_pga_control_regs #(.TIMEOUT_CYCLES(64)) input_pga_control_regs_i (
      .mclk(mclk), .rst(rst), .sclk(sclk), .csb(csb), .sdin(sdin),
      .mode_sel(mode),
      .left_sample(ls), .right_sample(16'sh0100), .sample_valid(sv),
      .left_alc_gain(ag[0]), .right_alc_gain(ag[1]),
      .left_ctl(lc), .right_ctl(rc), .sda_out(), .sda_oe(oe));
   host_port_model host_port_model_i (
      .sda_oe(oe), .sclk(sclk), .csb(csb), .sdin(sdin));

   always #25 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////////
   // Expected controls of one channel from shadow state
   function automatic chan_ctl_t want(input int r);
      chan_ctl_t c;
      c.power  = pwr[PWR_L_BIT + r];
      c.noninv = route[RT_L_NONINV + 4 * r];
      c.inv    = route[RT_L_INV + 4 * r];
      c.second = route[RT_L_SECOND + 4 * r];
      c.mute   = mute[r];
      c.alc    = sel[ALC_L_BIT - r];
      c.gain   = c.alc ? ag[r] : act[r];
      return c;
   endfunction

   // Compare and count
   task automatic chk(input string nm, input chan_ctl_t got, exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value %s exp %h got %h", nm, exp, got);
      end
   endtask

   // Both channels, then end-of-test line
   task automatic both(input string nm);
      chk(nm, lc, want(0));
      chk(nm, rc, want(1));
      $display("test %s done", nm);
   endtask

   // Register write and settle time
   task automatic wr(input logic [6:0] a, input logic [8:0] d);
      host_port_model_i.send({a, d});
      repeat (14) @(posedge mclk);
   endtask

   task automatic end_of_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      void'($urandom(32'h554C4FC0));
      pwr = PWR_RST;
      route = ROUTE_RST;
      sel = ALC_RST;
      mute = 2'b00;
      act = '{GAIN_RST[5:0], GAIN_RST[5:0]};
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      both("reset");
      repeat (4)
      begin
         pwr = 9'($urandom);
         route = 9'($urandom);
         wr(REG_PWR, pwr);
         wr(REG_ROUTE, route);
         both("switches");
      end
      ag[0] <= 6'($urandom);
      ag[1] <= 6'($urandom);
      mute = 2'b01;
      wr(REG_LGAIN, 9'h07F);
      both("pending");
      act = '{6'h3F, 6'h00};
      wr(REG_RGAIN, 9'h100);
      both("strobe");
      for (int s = 0; s < 4; s++)
      begin
         sel = 9'(s << 7);
         wr(REG_ALC, sel);
         both("alc");
      end
      sel = ALC_RST;
      wr(REG_ALC, sel);
      mute = 2'b00;
      wr(REG_LGAIN, 9'h1AA);
      both("zc wait");
      ls <= 16'shFFFB;
      sv <= 1'b1;
      @(posedge mclk);
      sv <= 1'b0;
      repeat (4) @(posedge mclk);
      act[0] = 6'h2A;
      both("zero cross");
      wr(REG_LGAIN, 9'h195);
      both("timeout wait");
      repeat (140) @(posedge mclk);
      act[0] = 6'h15;
      both("timeout");
      // Second reset with the strap low: 2-wire port only
      rst <= 1'b1;
      mode <= 1'b0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      pwr = PWR_RST;
      route = ROUTE_RST;
      act = '{GAIN_RST[5:0], GAIN_RST[5:0]};
      both("second reset");
      wr(REG_PWR, 9'h00C);
      both("3-wire ignored");
      host_port_model_i.send2({DEV_ADDR ^ 7'h01, 1'b0},
                              {REG_ROUTE, 9'h044}, acks);
      repeat (4) @(posedge mclk);
      chk("foreign acks", chan_ctl_t'(12'(acks)), '0);
      both("foreign address");
      route = 9'h044;
      host_port_model_i.send2({DEV_ADDR, 1'b0}, {REG_ROUTE, route}, acks);
      repeat (4) @(posedge mclk);
      chk("acks", chan_ctl_t'(12'(acks)), chan_ctl_t'(12'h003));
      both("2-wire write");
      end_of_test();
   end

   // Watchdog, well past the roughly 2300 cycles the tests need
   initial
   begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      end_of_test();
   end
endmodule
`default_nettype wire
